// >>> carrier_timer_pkg.sv
package carrier_timer_pkg;
	// Register offsets on the software port
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_PERIOD = 3'h1;
	localparam logic [2:0] OFS_LOW = 3'h2;
	localparam logic [2:0] OFS_HIGH = 3'h3;
	localparam logic [2:0] OFS_CARRIER = 3'h4;
	localparam logic [2:0] OFS_UCLK = 3'h5;
	localparam logic [2:0] OFS_LCNT = 3'h6;
	localparam logic [2:0] OFS_UCNT = 3'h7;

	// Control register fields
	localparam int CTRL_LRUN = 0;
	localparam int CTRL_URUN = 1;
	localparam int CTRL_OE = 2;
	localparam int CTRL_MODE_LO = 3;
	localparam int CTRL_CSEL_LO = 5;

	// Carrier output control fields
	localparam int CAR_GATE = 0;
	localparam int CAR_BUF = 1;
	localparam int CAR_RSEL = 2;

	// Operating modes
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_CASCADE = 2'h1;
	localparam logic [1:0] MODE_CARRIER = 2'h2;

	// Count clock select codes
	localparam logic [2:0] CSEL_DIV1_A = 3'h0;
	localparam logic [2:0] CSEL_DIV4_A = 3'h1;
	localparam logic [2:0] CSEL_DIV1_B = 3'h2;
	localparam logic [2:0] CSEL_DIV4_B = 3'h3;
	localparam logic [2:0] CSEL_DIV8 = 3'h4;

	// Prescaler terminal counts
	localparam int PRE_BITS = 4;
	localparam logic [1:0] PRE_DIV4_END = 2'h3;
	localparam logic [2:0] PRE_DIV8_END = 3'h7;
	localparam logic [3:0] PRE_DIV16_END = 4'hf;

	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [PRE_BITS-1:0] RST_PRE = 4'h0;
endpackage

// >>> carrier_timer.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Cascade square wave period 2*(256X+N+1) ticks
// - Output starts low when enabled
// - Clock select: /1, /4, /8, /16
// - Low match: irq, invert, use high compare
// - High match: irq, invert, use low compare
// - Either width match clears lower counter
// - Upper match with period raises upper irq
// - Upper irq rise copies buffer into gate
// - Carrier reaches pin only while gate set
// - Carrier control: select, buffer, gate bits
// - Gate writable only while output disabled
// - Width mode uses lower timer only
// - Start may shift first match one tick
// - Cascade: upper high byte, lower run controls
// - Cascade match clears both, lower irq only
// - Stopping lower run forces wave low
module carrier_timer
	import carrier_timer_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic timer_output_pin,
	output logic lower_match_irq,
	output logic upper_match_irq
);
	if (W < 2 || W > 8) begin : g_bad_width
		$error("carrier_timer: W must be 2..8");
	end

	typedef struct packed {
		logic lower_run;
		logic upper_run;
		logic oe;
		logic [1:0] mode;
		logic [2:0] lsel;
		logic [2:0] usel;
		logic [W-1:0] period;
		logic [W-1:0] low_w;
		logic [W-1:0] high_w;
		logic rsel;
		logic nrzb;
		logic nrz;
		logic [W-1:0] lcnt;
		logic [W-1:0] ucnt;
		logic [PRE_BITS-1:0] pre;
		logic hi_active;
		logic tog;
		logic pin;
		logic irq_l;
		logic irq_u;
		logic [7:0] rdata;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	// Divided count enables from a shared free-running prescaler.
	// Ticks are aligned to the prescaler, so a start may land just before one.
	function automatic logic tick_of(input logic [2:0] sel, input logic [PRE_BITS-1:0] pre);
		logic t;
		t = 1'b0;
		case (sel)
			CSEL_DIV1_A, CSEL_DIV1_B: t = 1'b1;
			CSEL_DIV4_A, CSEL_DIV4_B: t = (pre[1:0] == PRE_DIV4_END);
			CSEL_DIV8: t = (pre[2:0] == PRE_DIV8_END);
			default: t = (pre == PRE_DIV16_END);
		endcase
		return t;
	endfunction

	logic ltick;
	logic utick;
	logic [2*W-1:0] wide_cnt;
	logic carrier_out;

	assign ltick = tick_of(state_r.lsel, state_r.pre);
	assign utick = tick_of(state_r.usel, state_r.pre);
	assign wide_cnt = {state_r.ucnt, state_r.lcnt};

	always_comb begin
		state_nxt = state_r;
		state_nxt.pre = state_r.pre + 1'b1;
		state_nxt.irq_l = 1'b0;
		state_nxt.irq_u = 1'b0;
		state_nxt.rdata = RST_REG;
		carrier_out = 1'b0;

		if (wr) begin
			case (addr)
				OFS_CTRL: begin
					state_nxt.lower_run = wdata[CTRL_LRUN];
					state_nxt.upper_run = wdata[CTRL_URUN];
					state_nxt.oe = wdata[CTRL_OE];
					state_nxt.mode = wdata[CTRL_MODE_LO +: 2];
					state_nxt.lsel = wdata[CTRL_CSEL_LO +: 3];
				end
				OFS_PERIOD: state_nxt.period = wdata[W-1:0];
				OFS_LOW: state_nxt.low_w = wdata[W-1:0];
				OFS_HIGH: state_nxt.high_w = wdata[W-1:0];
				OFS_CARRIER: begin
					// Whole-byte write only; there is no per-bit access path
					state_nxt.rsel = wdata[CAR_RSEL];
					state_nxt.nrzb = wdata[CAR_BUF];
					if (!state_r.oe) begin
						state_nxt.nrz = wdata[CAR_GATE];
					end
				end
				OFS_UCLK: state_nxt.usel = wdata[2:0];
				default: ;
			endcase
		end

		if (rd) begin
			case (addr)
				OFS_CTRL: state_nxt.rdata = {state_r.lsel, state_r.mode, state_r.oe,
					state_r.upper_run, state_r.lower_run};
				OFS_PERIOD: state_nxt.rdata = 8'(state_r.period);
				OFS_LOW: state_nxt.rdata = 8'(state_r.low_w);
				OFS_HIGH: state_nxt.rdata = 8'(state_r.high_w);
				OFS_CARRIER: state_nxt.rdata = {5'h00, state_r.rsel, state_r.nrzb, state_r.nrz};
				OFS_UCLK: state_nxt.rdata = {5'h00, state_r.usel};
				OFS_LCNT: state_nxt.rdata = 8'(state_r.lcnt);
				default: state_nxt.rdata = 8'(state_r.ucnt);
			endcase
		end

		case (state_r.mode)
			MODE_8BIT: begin
				state_nxt.ucnt = '0;
				state_nxt.hi_active = 1'b0;
				if (!state_r.lower_run) begin
					state_nxt.lcnt = '0;
					state_nxt.tog = 1'b0;
				end else if (ltick) begin
					if (state_r.lcnt == state_r.low_w) begin
						state_nxt.lcnt = '0;
						state_nxt.tog = ~state_r.tog;
						state_nxt.irq_l = 1'b1;
					end else begin
						state_nxt.lcnt = state_r.lcnt + 1'b1;
					end
				end
			end
			MODE_CASCADE: begin
				state_nxt.hi_active = 1'b0;
				// Upper run bit has no say here; the lower run bit starts and clears both
				if (!state_r.lower_run) begin
					state_nxt.lcnt = '0;
					state_nxt.ucnt = '0;
					state_nxt.tog = 1'b0;
				end else if (ltick) begin
					if (wide_cnt == {state_r.period, state_r.low_w}) begin
						state_nxt.lcnt = '0;
						state_nxt.ucnt = '0;
						state_nxt.tog = ~state_r.tog;
						state_nxt.irq_l = 1'b1;
					end else begin
						{state_nxt.ucnt, state_nxt.lcnt} = wide_cnt + 1'b1;
					end
				end
			end
			MODE_CARRIER: begin
				if (!state_r.lower_run) begin
					state_nxt.lcnt = '0;
					state_nxt.hi_active = 1'b0;
					state_nxt.tog = 1'b0;
				end else if (ltick) begin
					if (state_r.lcnt == (state_r.hi_active ? state_r.high_w : state_r.low_w)) begin
						state_nxt.lcnt = '0;
						state_nxt.tog = ~state_r.tog;
						state_nxt.hi_active = ~state_r.hi_active;
						state_nxt.irq_l = 1'b1;
					end else begin
						state_nxt.lcnt = state_r.lcnt + 1'b1;
					end
				end
				if (!state_r.upper_run) begin
					state_nxt.ucnt = '0;
				end else if (utick) begin
					if (state_r.ucnt == state_r.period) begin
						state_nxt.ucnt = '0;
						state_nxt.irq_u = 1'b1;
					end else begin
						state_nxt.ucnt = state_r.ucnt + 1'b1;
					end
				end
				// The buffer does not survive a stop; software must load it again
				if (state_r.lower_run && !state_nxt.lower_run) begin
					state_nxt.nrzb = 1'b0;
				end
			end
			default: begin
				state_nxt.lcnt = '0;
				state_nxt.ucnt = '0;
				state_nxt.hi_active = 1'b0;
				state_nxt.tog = 1'b0;
			end
		endcase

		// Reload beats a software write in the same cycle
		if (state_nxt.irq_u && !state_r.irq_u) begin
			state_nxt.nrz = state_nxt.nrzb;
		end

		// Disabled output keeps the wave reset so it restarts from low
		if (!state_nxt.oe) begin
			state_nxt.tog = 1'b0;
		end

		// Stop in cascade drops the wave in the same cycle as the run bit
		if (state_nxt.mode == MODE_CASCADE && !state_nxt.lower_run) begin
			state_nxt.tog = 1'b0;
		end

		if (state_nxt.mode == MODE_CARRIER && !state_nxt.rsel) begin
			carrier_out = state_nxt.tog & state_nxt.nrz;
		end else begin
			carrier_out = state_nxt.tog;
		end
		state_nxt.pin = state_nxt.oe & carrier_out;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rdata = state_r.rdata;
	assign timer_output_pin = state_r.pin;
	assign lower_match_irq = state_r.irq_l;
	assign upper_match_irq = state_r.irq_u;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_upper_rise;
		state_r.irq_u && !$past(state_r.irq_u);
	endsequence

	sequence s_no_car_write;
		!$past(wr && addr == OFS_CARRIER);
	endsequence

	a_pin_needs_enable: assert property (state_r.pin |-> state_r.oe && state_r.tog)
		else $error("pin high while output disabled or wave low");

	a_gate_reload: assert property (s_upper_rise ##0 s_no_car_write |-> state_r.nrz == $past(state_r.nrzb))
		else $error("gate not reloaded from buffer on upper irq");

	a_gate_locked: assert property ($past(state_r.oe) && !state_r.irq_u && $past(state_r.lower_run)
		|-> state_r.nrz == $past(state_r.nrz))
		else $error("gate changed while output enabled");

	a_width_swap: assert property (state_r.irq_l && $past(state_r.mode) == MODE_CARRIER
		|-> state_r.hi_active != $past(state_r.hi_active) && state_r.lcnt == '0)
		else $error("width match did not swap comparand and clear");

	a_width_match: assert property (state_r.irq_l && $past(state_r.mode) == MODE_CARRIER
		|-> $past(state_r.lcnt) == ($past(state_r.hi_active) ? $past(state_r.high_w) : $past(state_r.low_w)))
		else $error("lower irq without comparand match");

	a_cascade_clear: assert property (state_r.irq_l && $past(state_r.mode) == MODE_CASCADE
		|-> state_r.lcnt == '0 && state_r.ucnt == '0 && !state_r.irq_u)
		else $error("cascade match did not clear both counters");

	a_cascade_stop: assert property (state_r.mode == MODE_CASCADE && !state_r.lower_run |-> !state_r.tog)
		else $error("cascade wave not forced low when stopped");

	a_gate_hold: assert property (state_r.pin && state_r.mode == MODE_CARRIER && !state_r.rsel |-> state_r.nrz)
		else $error("carrier on pin while gate clear");

	a_upper_match: assert property (state_r.irq_u |-> $past(state_r.ucnt) == $past(state_r.period)
		&& state_r.ucnt == '0)
		else $error("upper irq without period match");

	a_toggle_match: assert property (state_r.irq_l && $past(state_r.oe) && state_r.oe
		|-> state_r.tog != $past(state_r.tog))
		else $error("output did not invert on match");

	a_car_readback: assert property ($past(rd && addr == OFS_CARRIER)
		|-> state_r.rdata == {5'h00, $past(state_r.rsel), $past(state_r.nrzb), $past(state_r.nrz)})
		else $error("carrier control read back wrong");

	a_rdata_idle: assert property (!$past(rd) |-> state_r.rdata == RST_REG)
		else $error("read data not zero outside read cycle");

	a_reset_clear: assert property ($past(rst) |-> state_r.lcnt == '0 && state_r.ucnt == '0
		&& !state_r.lower_run && !state_r.oe && !state_r.pin)
		else $error("state not cleared by reset");

	a_oe_low_pin: assert property (!state_r.oe |-> !state_r.pin)
		else $error("pin high while output disabled");

	a_gate_write: assert property ($past(wr && addr == OFS_CARRIER && !state_r.oe) && !state_r.irq_u
		|-> state_r.nrz == $past(wdata[CAR_GATE]))
		else $error("gate write lost while output disabled");

	a_buf_write: assert property ($past(wr && addr == OFS_CARRIER) |-> state_r.nrzb == $past(wdata[CAR_BUF]))
		else $error("buffer bit write lost");

	a_lower_stop: assert property (!state_r.lower_run && $past(!state_r.lower_run) |-> state_r.lcnt == '0)
		else $error("lower counter not held clear while stopped");

	a_upper_irq_mode: assert property (state_r.irq_u |-> $past(state_r.mode) == MODE_CARRIER)
		else $error("upper irq outside carrier mode");

	a_cascade_wrap: assert property (state_r.irq_l && $past(state_r.mode) == MODE_CASCADE
		|-> $past(wide_cnt) == {$past(state_r.period), $past(state_r.low_w)})
		else $error("cascade irq without full match");

	a_buf_cleared: assert property ($past(state_r.mode == MODE_CARRIER && state_r.lower_run)
		&& !state_r.lower_run |-> !state_r.nrzb)
		else $error("buffer bit kept over a stop");

	a_pin_ungated: assert property (state_r.mode == MODE_CARRIER && state_r.rsel
		|-> state_r.pin == (state_r.oe && state_r.tog))
		else $error("width output does not follow wave");

	a_pin_gated: assert property (state_r.mode == MODE_CARRIER && !state_r.rsel
		|-> state_r.pin == (state_r.oe && state_r.tog && state_r.nrz))
		else $error("carrier output does not follow gate");

	a_lirq_cause: assert property (state_r.irq_l |-> $past(state_r.lower_run) && $past(ltick))
		else $error("lower irq without a count tick");
endmodule

// >>> carrier_pin_load.sv
`timescale 1ns/10ps
// Load on the timer output; widths are counted in clk cycles between level changes
module carrier_pin_load (
	input wire logic clk,
	input wire logic pin,
	output int hi_w,
	output int lo_w,
	output int n_edge
);
	int cnt;
	logic last;
	initial begin
		cnt = 0;
		last = 1'b0;
		hi_w = 0;
		lo_w = 0;
		n_edge = 0;
	end
	always @(posedge clk) begin
		if (pin !== last) begin
			if (last === 1'b1) begin
				hi_w <= cnt;
			end else begin
				lo_w <= cnt;
			end
			cnt <= 1;
			last <= pin;
			n_edge <= n_edge + 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> test_cascaded_carrier_pwm_timer.sv
`timescale 1ns/10ps
module test_cascaded_carrier_pwm_timer;
	import carrier_timer_pkg::*;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic pin;
	logic uirq;
	logic [7:0] v;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_uirq = 0;
	int n_lirq = 0;
	int n_edge_u = 0;
	int e1;
	logic lirq;
	int e0;
	int hi_w;
	int lo_w;
	int n_edge;
	int divs [6] = '{1, 4, 1, 4, 8, 16};

	carrier_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.timer_output_pin(pin), .lower_match_irq(lirq), .upper_match_irq(uirq));
	carrier_pin_load load (.clk(clk), .pin(pin), .hi_w(hi_w), .lo_w(lo_w), .n_edge(n_edge));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic end_sim();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (uirq === 1'b1) begin
			n_uirq <= n_uirq + 1;
			// Pin edges seen before the irq edge; the gate opens on that same edge
			n_edge_u <= n_edge;
		end
		if (lirq === 1'b1) begin
			n_lirq <= n_lirq + 1;
		end
		if (cyc == LIMIT) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_edges(input int k);
		int t;
		t = n_edge + k;
		repeat (3000) if (n_edge < t) @(posedge clk);
	endtask

	task automatic wait_uirq();
		int t;
		t = n_uirq + 1;
		repeat (500) if (n_uirq < t) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask

	function automatic logic [7:0] cw(input logic [2:0] cs, input logic [1:0] m, input logic [1:0] run);
		return {cs, m, 1'b1, run};
	endfunction

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_reg(OFS_CTRL, v);
		chk(v, RST_REG);
		rd_reg(OFS_LCNT, v);
		chk(v, RST_REG);
		chk(pin, 1'b0);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			wr_reg(OFS_CTRL, 8'h00);
			wr_reg(OFS_LOW, 8'h03);
			wr_reg(OFS_HIGH, 8'h05);
			wr_reg(OFS_CARRIER, 8'h04);
			wr_reg(OFS_CTRL, cw(i[2:0], MODE_CARRIER, 2'b00));
			repeat (3) @(posedge clk);
			chk(pin, 1'b0);
			wr_reg(OFS_CTRL, cw(i[2:0], MODE_CARRIER, 2'b01));
			wait_edges(4);
			chk(lo_w, 4 * divs[i]);
			chk(hi_w, 6 * divs[i]);
		end
		$display("width test done");
		wr_reg(OFS_CTRL, 8'h00);
		wr_reg(OFS_PERIOD, 8'h01);
		wr_reg(OFS_LOW, 8'h02);
		e0 = n_uirq;
		e1 = n_lirq;
		wr_reg(OFS_CTRL, cw(3'h0, MODE_CASCADE, 2'b01));
		wait_edges(3);
		chk(n_lirq - e1, 3);
		chk(hi_w, 259);
		chk(lo_w, 259);
		chk(n_uirq, e0);
		wr_reg(OFS_CTRL, cw(3'h0, MODE_CASCADE, 2'b00));
		repeat (3) @(posedge clk);
		chk(pin, 1'b0);
		$display("cascade test done");
		wr_reg(OFS_CTRL, 8'h00);
		wr_reg(OFS_PERIOD, 8'd40);
		wr_reg(OFS_LOW, 8'h01);
		wr_reg(OFS_HIGH, 8'h01);
		wr_reg(OFS_UCLK, 8'h00);
		wr_reg(OFS_CARRIER, 8'h02);
		rd_reg(OFS_CARRIER, v);
		chk(v, 8'h02);
		e0 = n_edge;
		wr_reg(OFS_CTRL, cw(3'h0, MODE_CARRIER, 2'b11));
		wait_uirq();
		chk(n_edge_u, e0);
		rd_reg(OFS_CARRIER, v);
		chk(v, 8'h03);
		// Gate field of this rewrite must be dropped while the output runs
		wr_reg(OFS_CARRIER, 8'h00);
		rd_reg(OFS_CARRIER, v);
		chk(v, 8'h01);
		wait_edges(4);
		chk(hi_w, 2);
		wait_uirq();
		repeat (2) @(posedge clk);
		rd_reg(OFS_CARRIER, v);
		chk(v, 8'h00);
		chk(pin, 1'b0);
		$display("carrier test done");
		end_sim();
	end
endmodule
